/* hw/mdd_datapath.sv */
// multiplier, iterative divider and 40-bit accumulator datapath
// assumes decoder supplies operands from the working registers and
// holds op_valid until op_ready; apb3 master drives the registers
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module mdd_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operation request
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic acc_sel,
  input wire logic [2:0] mcu_mode,
  input wire logic [15:0] op_x,
  input wire logic [15:0] op_y,
  input wire logic [39:0] shift_data,
  output logic op_ready,
  // divide operands
  input wire logic div_signed,
  input wire logic div_long,
  input wire logic [15:0] dvd_odd,
  input wire logic [15:0] dvd_even,
  input wire logic [15:0] divisor,
  // results
  output logic mul_valid,
  output logic mul_wide,
  output logic [31:0] mul_result,
  output logic div_done,
  output logic [15:0] work_reg_zero,
  output logic [15:0] work_reg_one,
  output logic wb_valid,
  output logic [15:0] wb_word,
  output logic arith_trap,
  output logic store_clamp_enable
);

  // ==========================================================
  // registers
  logic [31:0] ctrl_q;
  logic [2:0] trap_en_q;
  logic [39:0] acc_a_q, acc_b_q;
  logic guard_a_q, guard_b_q, clamp_a_q, clamp_b_q;
  logic div_busy_q;
  logic [4:0] div_cnt_q;
  logic [16:0] rem_q;
  logic [15:0] shq_q, dvs_q;
  logic neg_q_q, neg_r_q;
  logic mul_valid_q, mul_wide_q, div_done_q, wb_valid_q, trap_q;
  logic [31:0] mul_result_q, prdata_q;
  logic [15:0] wr_zero_q, wr_one_q, wb_word_q;

  // ==========================================================
  // configuration
  wire sign_mode_select = ctrl_q[mdd_pkg::CTL_SIGN_BIT];
  wire acc_a_clamp_enable = ctrl_q[mdd_pkg::CTL_CLAMP_A_BIT];
  wire acc_b_clamp_enable = ctrl_q[mdd_pkg::CTL_CLAMP_B_BIT];
  wire clamp_range_select = ctrl_q[mdd_pkg::CTL_RANGE_BIT];
  wire round_style_select = ctrl_q[mdd_pkg::CTL_ROUND_BIT];
  wire int_mode_select = ctrl_q[mdd_pkg::CTL_INT_BIT];
  wire acc_a_ovf_trap_en = trap_en_q[mdd_pkg::TE_A_BIT];
  wire acc_b_ovf_trap_en = trap_en_q[mdd_pkg::TE_B_BIT];
  wire fatal_ovf_trap_en = trap_en_q[mdd_pkg::TE_FATAL_BIT];

  // ==========================================================
  // op decode
  wire accept = op_valid & op_ready;
  wire is_mcu = op_code == mdd_pkg::OP_MCU_PRODUCT;
  wire is_div = op_code == mdd_pkg::OP_DIVIDE;
  wire is_sqr = op_code == mdd_pkg::OP_SQR_ACCUM
              | op_code == mdd_pkg::OP_SQR_LOAD;
  wire is_euclid = op_code == mdd_pkg::OP_EUCLID_LOAD
                 | op_code == mdd_pkg::OP_EUCLID_ACCUM;
  wire is_clear = op_code == mdd_pkg::OP_CLEAR_ACC;
  wire is_store = op_code == mdd_pkg::OP_PREFETCH_STORE;
  // every accumulator op except the store touches the adder
  wire adder_op = accept & (op_code >= mdd_pkg::OP_CLEAR_ACC)
                & (op_code <= mdd_pkg::OP_ADD_DATA) & !is_store;
  wire do_wb = accept & (is_clear | is_store
             | op_code == mdd_pkg::OP_PROD_ACCUM
             | op_code == mdd_pkg::OP_PROD_SUBTRACT);

  // ==========================================================
  // shared 17x17 multiplier
  wire byte_mode = mcu_mode == mdd_pkg::MM_BYTE;
  wire lit_mode = mcu_mode == mdd_pkg::MM_SLIT
                | mcu_mode == mdd_pkg::MM_ULIT;
  wire mcu_x_signed = mcu_mode == mdd_pkg::MM_SS
                    | mcu_mode == mdd_pkg::MM_SLIT;
  wire mcu_y_signed = mcu_mode == mdd_pkg::MM_SS
                    | mcu_mode == mdd_pkg::MM_US;
  wire [15:0] diff_xy = op_x - op_y;
  wire [15:0] dsp_x = is_euclid ? diff_xy : op_x;
  wire [15:0] dsp_y = (is_euclid | is_sqr) ? dsp_x : op_y;
  wire [15:0] mcu_x = byte_mode ? {8'h00, op_x[7:0]} : op_x;
  wire [15:0] mcu_y = byte_mode ? {8'h00, op_y[7:0]}
                    : lit_mode ? {11'h000, op_y[4:0]} : op_y;
  wire [15:0] mx = is_mcu ? mcu_x : dsp_x;
  wire [15:0] my = is_mcu ? mcu_y : dsp_y;
  wire dsp_signed = !sign_mode_select;
  wire sx = is_mcu ? mcu_x_signed : dsp_signed;
  wire sy = is_mcu ? mcu_y_signed : dsp_signed;
  wire [16:0] m_a = {sx & mx[15], mx};
  wire [16:0] m_b = {sy & my[15], my};
  wire signed [33:0] prod_full = $signed(m_a) * $signed(m_b);
  wire [32:0] prod33 = prod_full[32:0];
  // q15 times q15 needs one left shift for a 1.31 result
  wire [32:0] scaled = int_mode_select ? prod33
                     : {prod33[31:0], 1'b0};
  wire [39:0] prod40 = {{7{scaled[32]}}, scaled};

  // ==========================================================
  // 40-bit adder/subtracter
  wire [39:0] acc_t = acc_sel ? acc_b_q : acc_a_q;
  wire [39:0] acc_o = acc_sel ? acc_a_q : acc_b_q;
  wire zero_a = is_clear | op_code == mdd_pkg::OP_PROD_LOAD
              | op_code == mdd_pkg::OP_SQR_LOAD
              | op_code == mdd_pkg::OP_NEG_PROD_LOAD
              | op_code == mdd_pkg::OP_EUCLID_LOAD
              | op_code == mdd_pkg::OP_ACC_NEG
              | op_code == mdd_pkg::OP_LOAD_ACC;
  wire do_subtract = op_code == mdd_pkg::OP_PROD_SUBTRACT
                   | op_code == mdd_pkg::OP_NEG_PROD_LOAD
                   | op_code == mdd_pkg::OP_ACC_SUB
                   | op_code == mdd_pkg::OP_ACC_NEG;
  wire [39:0] b_raw = is_clear ? 40'h00_0000_0000
                    : (op_code == mdd_pkg::OP_ACC_ADD
                       | op_code == mdd_pkg::OP_ACC_SUB) ? acc_o
                    : op_code == mdd_pkg::OP_ACC_NEG ? acc_t
                    : (op_code == mdd_pkg::OP_LOAD_ACC
                       | op_code == mdd_pkg::OP_ADD_DATA) ? shift_data
                    : prod40;
  wire [39:0] a_in = zero_a ? 40'h00_0000_0000 : acc_t;
  wire [39:0] b_eff = do_subtract ? ~b_raw : b_raw;
  // carry-in doubles as borrow: high means no borrow on subtract
  wire [40:0] sum41 = {1'b0, a_in} + {1'b0, b_eff}
                    + {40'h00_0000_0000, do_subtract};
  wire [39:0] sum = sum41[39:0];

  // ==========================================================
  // overflow and clamp, all from the raw sum
  wire ovf39 = (a_in[39] == b_eff[39]) & (sum[39] != a_in[39]);
  wire guard_raw = ~((&sum[39:32]) | ~(|sum[39:32]));
  wire ovf31 = ovf39 | ~((&sum[39:31]) | ~(|sum[39:31]));
  wire towards_pos = ovf39 ? ~a_in[39] : ~sum[39];
  wire clamp_en = acc_sel ? acc_b_clamp_enable : acc_a_clamp_enable;
  wire range_40 = clamp_en & clamp_range_select;
  wire range_32 = clamp_en & !clamp_range_select;
  wire [39:0] clamp_val =
      range_40 ? (towards_pos ? mdd_pkg::MAX_40 : mdd_pkg::MIN_40)
               : (towards_pos ? mdd_pkg::MAX_32 : mdd_pkg::MIN_32);
  wire clamp_hit = range_40 ? ovf39 : ovf31;
  wire [39:0] acc_new = clamp_en & clamp_hit ? clamp_val
                      : sum;
  // guard bits play no part in 32-bit clamping
  wire guard_new = guard_raw & !range_32;
  // disabled clamp falls back to recording bit 39 overflow
  wire sticky_set = clamp_en ? clamp_hit : ovf39;
  wire guard_trap = guard_new
                  & (acc_sel ? acc_b_ovf_trap_en : acc_a_ovf_trap_en);
  wire fatal_trap = !clamp_en & ovf39 & fatal_ovf_trap_en;
  wire trap_d = adder_op & (guard_trap | fatal_trap);

  // ==========================================================
  // write-back rounding of the non-target accumulator
  wire lsw_half = acc_o[15:0] == mdd_pkg::HALF_LSW;
  wire round_up = acc_o[15] & (round_style_select
                | !lsw_half | acc_o[16]);
  wire [15:0] wb_word_d = acc_o[31:16] + {15'h0000, round_up};

  // ==========================================================
  // iterative divider
  wire dvd_neg = div_signed & (div_long ? dvd_odd[15] : dvd_even[15]);
  wire [31:0] dvd32 = div_long ? {dvd_odd, dvd_even}
                    : {{16{div_signed & dvd_even[15]}}, dvd_even};
  wire [31:0] dvd_mag = dvd_neg ? 32'h0000_0000 - dvd32 : dvd32;
  wire dvs_neg = div_signed & divisor[15];
  wire [15:0] dvs_mag = dvs_neg ? 16'h0000 - divisor : divisor;
  wire [16:0] trial = {rem_q[15:0], shq_q[15]};
  wire fits = trial >= {1'b0, dvs_q};
  wire [16:0] rem_d = fits ? trial - {1'b0, dvs_q} : trial;
  wire [15:0] shq_d = {shq_q[14:0], fits};
  wire last_step = div_busy_q & (div_cnt_q == 5'h01);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_busy_q <= 1'b0;
      div_cnt_q <= 5'h00;
      rem_q <= 17'h0_0000;
      shq_q <= 16'h0000;
      dvs_q <= 16'h0000;
      neg_q_q <= 1'b0;
      neg_r_q <= 1'b0;
    end else if (accept & is_div) begin
      div_busy_q <= 1'b1;
      div_cnt_q <= mdd_pkg::DIV_STEPS;
      rem_q <= {1'b0, dvd_mag[31:16]};
      shq_q <= dvd_mag[15:0];
      dvs_q <= dvs_mag;
      neg_q_q <= dvd_neg ^ dvs_neg;
      neg_r_q <= dvd_neg;
    end else if (div_busy_q) begin
      div_busy_q <= !last_step;
      div_cnt_q <= div_cnt_q - 5'h01;
      rem_q <= rem_d;
      shq_q <= shq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_done_q <= 1'b0;
      wr_zero_q <= 16'h0000;
      wr_one_q <= 16'h0000;
    end else begin
      div_done_q <= last_step;
      if (last_step) begin
        wr_zero_q <= neg_q_q ? 16'h0000 - shq_d : shq_d;
        wr_one_q <= neg_r_q ? 16'h0000 - rem_d[15:0] : rem_d[15:0];
      end
    end
  end

  // ==========================================================
  // accumulators and result strobes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_a_q <= 40'h00_0000_0000;
      acc_b_q <= 40'h00_0000_0000;
      guard_a_q <= 1'b0;
      guard_b_q <= 1'b0;
    end else if (adder_op) begin
      if (acc_sel) begin
        acc_b_q <= acc_new;
        guard_b_q <= guard_new;
      end else begin
        acc_a_q <= acc_new;
        guard_a_q <= guard_new;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mul_valid_q <= 1'b0;
      mul_wide_q <= 1'b0;
      mul_result_q <= 32'h0000_0000;
      wb_valid_q <= 1'b0;
      wb_word_q <= 16'h0000;
      trap_q <= 1'b0;
    end else begin
      mul_valid_q <= accept & is_mcu;
      wb_valid_q <= do_wb;
      trap_q <= trap_d;
      if (accept & is_mcu) begin
        mul_wide_q <= !byte_mode;
        mul_result_q <= byte_mode ? {16'h0000, prod33[15:0]}
                      : prod33[31:0];
      end
      if (do_wb) wb_word_q <= wb_word_d;
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  wire setup = psel & !penable;
  wire wr_en = psel & penable & pwrite;
  wire hit_ctrl = paddr == mdd_pkg::ADDR_CTRL;
  wire hit_status = paddr == mdd_pkg::ADDR_STATUS;
  wire hit_trap = paddr == mdd_pkg::ADDR_TRAP_EN;
  wire hit_any = hit_ctrl | hit_status | hit_trap
               | paddr == mdd_pkg::ADDR_ACC_A_LO
               | paddr == mdd_pkg::ADDR_ACC_A_HI
               | paddr == mdd_pkg::ADDR_ACC_B_LO
               | paddr == mdd_pkg::ADDR_ACC_B_HI;
  wire clr_wr = wr_en & hit_status;
  wire clr_a = clr_wr & (pwdata[mdd_pkg::ST_CLAMP_A_BIT]
             | pwdata[mdd_pkg::ST_EITHER_CLAMP_BIT]);
  wire clr_b = clr_wr & (pwdata[mdd_pkg::ST_CLAMP_B_BIT]
             | pwdata[mdd_pkg::ST_EITHER_CLAMP_BIT]);
  wire set_a = adder_op & !acc_sel & sticky_set;
  wire set_b = adder_op & acc_sel & sticky_set;
  wire either_guard_overflow = guard_a_q | guard_b_q;
  wire either_clamp_flag = clamp_a_q | clamp_b_q;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[mdd_pkg::ST_GUARD_A_BIT] = guard_a_q;
    status_word[mdd_pkg::ST_GUARD_B_BIT] = guard_b_q;
    status_word[mdd_pkg::ST_CLAMP_A_BIT] = clamp_a_q;
    status_word[mdd_pkg::ST_CLAMP_B_BIT] = clamp_b_q;
    status_word[mdd_pkg::ST_EITHER_GUARD_BIT] = either_guard_overflow;
    status_word[mdd_pkg::ST_EITHER_CLAMP_BIT] = either_clamp_flag;
  end
  wire [31:0] rd_mux =
      hit_ctrl ? ctrl_q
    : hit_status ? status_word
    : hit_trap ? {29'h0000_0000, trap_en_q}
    : paddr == mdd_pkg::ADDR_ACC_A_LO ? acc_a_q[31:0]
    : paddr == mdd_pkg::ADDR_ACC_A_HI ? {24'h00_0000, acc_a_q[39:32]}
    : paddr == mdd_pkg::ADDR_ACC_B_LO ? acc_b_q[31:0]
    : paddr == mdd_pkg::ADDR_ACC_B_HI ? {24'h00_0000, acc_b_q[39:32]}
    : 32'h0000_0000;
  // only documented control bits are writable, rest read zero
  wire [31:0] ctrl_mask = (32'h1 << mdd_pkg::CTL_SIGN_BIT)
    | (32'h1 << mdd_pkg::CTL_CLAMP_A_BIT)
    | (32'h1 << mdd_pkg::CTL_CLAMP_B_BIT)
    | (32'h1 << mdd_pkg::CTL_STORE_BIT)
    | (32'h1 << mdd_pkg::CTL_RANGE_BIT)
    | (32'h1 << mdd_pkg::CTL_ROUND_BIT)
    | (32'h1 << mdd_pkg::CTL_INT_BIT);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= mdd_pkg::CTL_RESET;
      trap_en_q <= 3'h0;
      clamp_a_q <= 1'b0;
      clamp_b_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_en & hit_ctrl) ctrl_q <= pwdata & ctrl_mask;
      if (wr_en & hit_trap) trap_en_q <= pwdata[2:0];
      // a set in the same cycle as a clear wins
      clamp_a_q <= set_a | (clamp_a_q & !clr_a);
      clamp_b_q <= set_b | (clamp_b_q & !clr_b);
      if (setup) prdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & !hit_any;
  assign op_ready = !div_busy_q;
  assign mul_valid = mul_valid_q;
  assign mul_wide = mul_wide_q;
  assign mul_result = mul_result_q;
  assign div_done = div_done_q;
  assign work_reg_zero = wr_zero_q;
  assign work_reg_one = wr_one_q;
  assign wb_valid = wb_valid_q;
  assign wb_word = wb_word_q;
  assign arith_trap = trap_q;
  assign store_clamp_enable = ctrl_q[mdd_pkg::CTL_STORE_BIT];

  // ==========================================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_div_start;
    accept & is_div;
  endsequence
  sequence s_div_run;
    !op_ready [*8];
  endsequence
  AST_DIV_BUSY: assert property (s_div_start |=> s_div_run)
    else $error("divider accepted a request while busy");
  AST_DIV_LATENCY: assert property (s_div_start |-> ##17 div_done_q
    and ##16 !div_done_q)
    else $error("divide did not finish after sixteen steps");
  AST_CLAMP_STICKY: assert property (clamp_a_q & !clr_a |=> clamp_a_q)
    else $error("clamp flag fell without a software clear");
  AST_GUARD_32: assert property (adder_op & range_32 & !acc_sel
    |=> !guard_a_q)
    else $error("guard flag set in 32-bit clamp mode");
  AST_SAT40_VALUE: assert property (adder_op & range_40 & ovf39
    & !acc_sel |=> (acc_a_q == mdd_pkg::MAX_40
    || acc_a_q == mdd_pkg::MIN_40) && clamp_a_q)
    else $error("40-bit clamp did not load an extreme value");
  AST_EITHER_GUARD: assert property (adder_op & guard_new
    |=> status_word[mdd_pkg::ST_EITHER_GUARD_BIT])
    else $error("combined guard bit missed an overflow");
  AST_GUARD_TRAP: assert property (adder_op & !acc_sel & guard_new
    & acc_a_ovf_trap_en |=> arith_trap)
    else $error("guard overflow trap not raised");
  AST_WRAP: assert property (adder_op & !clamp_en & !acc_sel
    |=> acc_a_q == $past(sum))
    else $error("unclamped accumulator did not wrap");
  AST_CLEAR_ZERO: assert property (accept & is_clear & !acc_sel
    |=> acc_a_q == 40'h00_0000_0000 && wb_valid)
    else $error("clear did not zero the accumulator");
  AST_BYTE_PRODUCT: assert property (accept & is_mcu & byte_mode
    |=> mul_valid && !mul_wide && mul_result[31:16] == 16'h0000)
    else $error("byte product wider than 16 bits");

endmodule
`default_nettype wire

/* hw/mdd_pkg.sv */
// constants, opcodes and register map of the arithmetic datapath
// assumes a 100 MHz core clock and an apb3 register port
package mdd_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TRAP_EN = 12'h008;
  localparam logic [11:0] ADDR_ACC_A_LO = 12'h00C;
  localparam logic [11:0] ADDR_ACC_A_HI = 12'h010;
  localparam logic [11:0] ADDR_ACC_B_LO = 12'h014;
  localparam logic [11:0] ADDR_ACC_B_HI = 12'h018;

  // ==========================================================
  // core_control_reg fields
  localparam int CTL_SIGN_BIT = 12;
  localparam int CTL_CLAMP_A_BIT = 7;
  localparam int CTL_CLAMP_B_BIT = 6;
  localparam int CTL_STORE_BIT = 5;
  localparam int CTL_RANGE_BIT = 4;
  localparam int CTL_ROUND_BIT = 1;
  localparam int CTL_INT_BIT = 0;
  localparam logic [31:0] CTL_RESET = 32'h0000_0020;

  // cpu_status_reg fields
  localparam int ST_GUARD_A_BIT = 15;
  localparam int ST_GUARD_B_BIT = 14;
  localparam int ST_CLAMP_A_BIT = 13;
  localparam int ST_CLAMP_B_BIT = 12;
  localparam int ST_EITHER_GUARD_BIT = 11;
  localparam int ST_EITHER_CLAMP_BIT = 10;

  // interrupt_control_one trap enable fields
  localparam int TE_A_BIT = 0;
  localparam int TE_B_BIT = 1;
  localparam int TE_FATAL_BIT = 2;

  // ==========================================================
  // clamp values
  localparam logic [39:0] MAX_40 = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] MIN_40 = 40'h80_0000_0000;
  localparam logic [39:0] MAX_32 = 40'h00_7FFF_FFFF;
  localparam logic [39:0] MIN_32 = 40'h00_8000_0000;

  localparam logic [4:0] DIV_STEPS = 5'h10;
  localparam logic [15:0] HALF_LSW = 16'h8000;

  // ==========================================================
  typedef enum logic [4:0] {
    OP_NONE = 5'b00000,
    OP_MCU_PRODUCT = 5'b00001,
    OP_DIVIDE = 5'b00010,
    OP_CLEAR_ACC = 5'b00011,
    OP_PROD_ACCUM = 5'b00100,
    OP_SQR_ACCUM = 5'b00101,
    OP_PROD_SUBTRACT = 5'b00110,
    OP_PROD_LOAD = 5'b00111,
    OP_SQR_LOAD = 5'b01000,
    OP_NEG_PROD_LOAD = 5'b01001,
    OP_EUCLID_LOAD = 5'b01010,
    OP_EUCLID_ACCUM = 5'b01011,
    OP_PREFETCH_STORE = 5'b01100,
    OP_ACC_ADD = 5'b01101,
    OP_ACC_SUB = 5'b01110,
    OP_ACC_NEG = 5'b01111,
    OP_LOAD_ACC = 5'b10000,
    OP_ADD_DATA = 5'b10001
  } mdd_op_t;

  typedef enum logic [2:0] {
    MM_SS = 3'b000,
    MM_UU = 3'b001,
    MM_US = 3'b010,
    MM_SLIT = 3'b011,
    MM_ULIT = 3'b100,
    MM_BYTE = 3'b101
  } mdd_mcu_mode_t;

endpackage

/* test/mdd_wreg_model.sv */
// working register file model that stores each divide result
// assumes div_done is a one-cycle pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
module mdd_wreg_model (
  // clock
  input wire logic clk,
  // divide results
  input wire logic div_done,
  input wire logic [15:0] work_reg_zero,
  input wire logic [15:0] work_reg_one,
  // stored words
  output logic [15:0] w0_q,
  output logic [15:0] w1_q
);
  // ==========================================================
  // capture on the pulse only, outputs may move later
  always_ff @(posedge clk) begin
    if (div_done) begin
      w0_q <= work_reg_zero;
      w1_q <= work_reg_one;
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the arithmetic datapath
// assumes apb3 with zero wait states and the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, mul_result;
  logic pready, pslverr, er, op_ready, mul_valid, mul_wide, div_done;
  logic op_valid = 0, acc_sel = 0, div_signed = 0, div_long = 0;
  logic [4:0] op_code = '0;
  logic [2:0] mcu_mode = '0;
  logic [15:0] op_x = '0, op_y = '0, dvd_odd = '0, dvd_even = '0;
  logic [15:0] divisor = '0, work_reg_zero, work_reg_one, w0, w1, wb_word;
  logic [39:0] shift_data = '0;
  logic wb_valid, arith_trap, store_clamp_enable;
  int n_mismatch = 0, total_checks = 0, n;
  always #5 clk = ~clk;
  mdd_datapath dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .acc_sel,
    .mcu_mode, .op_x, .op_y, .shift_data, .op_ready, .div_signed,
    .div_long, .dvd_odd, .dvd_even, .divisor, .mul_valid, .mul_wide,
    .mul_result, .div_done, .work_reg_zero, .work_reg_one, .wb_valid,
    .wb_word, .arith_trap, .store_clamp_enable);
  mdd_wreg_model wreg_u (.clk, .div_done, .work_reg_zero, .work_reg_one,
    .w0_q(w0), .w1_q(w1));
  // ==========================================================
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic op(input logic [4:0] c, input logic [15:0] x, y,
                    input logic [39:0] sd);
    @(posedge clk);
    {op_valid, op_code} <= {1'b1, c};
    {op_x, op_y} <= {x, y};
    shift_data <= sd;
    do @(posedge clk); while (op_ready !== 1'b1);
    op_valid <= 0;
  endtask
  task automatic mu(input logic [2:0] m, input logic [15:0] x, y,
                    input logic [31:0] e, input logic wd);
    mcu_mode <= m;
    op(mdd_pkg::OP_MCU_PRODUCT, x, y, 0);
    #1;
    chk("mul valid", mul_valid, 1);
    chk("mul result", mul_result, e);
    chk("mul wide", mul_wide, wd);
  endtask
  task automatic dv(input logic sg, lg, input logic [15:0] o, v, d, q, r);
    {div_signed, div_long} <= {sg, lg};
    {dvd_odd, dvd_even, divisor} <= {o, v, d};
    op(mdd_pkg::OP_DIVIDE, 0, 0, 0);
    n = 0;
    #1;
    while (div_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("div cycles", n, 16);
    @(posedge clk);
    #1;
    chk("quotient", w0, q);
    chk("remainder", w1, r);
  endtask
  task automatic rda(input logic [39:0] e);
    apb(0, mdd_pkg::ADDR_ACC_A_LO, 0);
    chk("acc lo", rd, e[31:0]);
    apb(0, mdd_pkg::ADDR_ACC_A_HI, 0);
    chk("acc hi", rd, e[39:32]);
  endtask
  task automatic sat(input logic [31:0] c, input logic [39:0] p, e,
                     input logic [5:0] st, input logic t);
    apb(1, mdd_pkg::ADDR_CTRL, c);
    op(mdd_pkg::OP_LOAD_ACC, 0, 0, p);
    op(mdd_pkg::OP_ADD_DATA, 0, 0, 40'h00_0000_0001);
    #1;
    chk("trap", arith_trap, t);
    rda(e);
    apb(0, mdd_pkg::ADDR_STATUS, 0);
    chk("status", rd[15:10], st);
    apb(1, mdd_pkg::ADDR_STATUS, 32'h0000_0400);
    apb(0, mdd_pkg::ADDR_STATUS, 0);
    chk("flags cleared", {rd[13], rd[10]}, 0);
  endtask
  // ==========================================================
  // generous bound: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    apb(0, mdd_pkg::ADDR_CTRL, 0);
    chk("ctrl reset", rd, 32'h0000_0020);
    chk("store clamp", store_clamp_enable, 1);
    apb(0, 12'h0FC, 0);
    chk("slverr", er, 1);
    mu(mdd_pkg::MM_SS, 16'hFFFD, 16'h0005, 32'hFFFF_FFF1, 1);
    mu(mdd_pkg::MM_UU, 16'hFFFD, 16'h0005, 32'h0004_FFF1, 1);
    mu(mdd_pkg::MM_US, 16'hFFFD, 16'h0005, 32'h0004_FFF1, 1);
    mu(mdd_pkg::MM_SLIT, 16'hFFFD, 16'h0025, 32'hFFFF_FFF1, 1);
    mu(mdd_pkg::MM_ULIT, 16'hFFFD, 16'h0025, 32'h0004_FFF1, 1);
    mu(mdd_pkg::MM_BYTE, 16'h00FF, 16'h00FF, 32'h0000_FE01, 0);
    dv(1, 1, 16'hFFFF, 16'hFF00, 16'h0010, 16'hFFF0, 0);
    dv(0, 0, 16'h0000, 16'h0064, 16'h0007, 16'h000E, 16'h0002);
    apb(1, mdd_pkg::ADDR_CTRL, 32'h0000_0021);
    op(mdd_pkg::OP_PROD_LOAD, 16'h7FFF, 16'h7FFF, 0);
    rda(40'h00_3FFF_0001);
    op(mdd_pkg::OP_LOAD_ACC, 0, 0, 40'h00_0000_0005);
    op(mdd_pkg::OP_ACC_NEG, 0, 0, 0);
    rda(40'hFF_FFFF_FFFB);
    // tie case on the low word, even bit 16: convergent keeps it
    acc_sel <= 1;
    op(mdd_pkg::OP_LOAD_ACC, 0, 0, 40'h00_1234_8000);
    acc_sel <= 0;
    op(mdd_pkg::OP_CLEAR_ACC, 0, 0, 0);
    #1;
    chk("wb valid", wb_valid, 1);
    chk("wb word", wb_word, 16'h1234);
    rda(40'h00_0000_0000);
    apb(1, mdd_pkg::ADDR_CTRL, 32'h0000_0020);
    op(mdd_pkg::OP_PROD_LOAD, 16'h7FFF, 16'h7FFF, 0);
    rda(40'h00_7FFE_0002);
    apb(1, mdd_pkg::ADDR_CTRL, 32'h0000_1021);
    op(mdd_pkg::OP_PROD_LOAD, 16'hFFFF, 16'hFFFF, 0);
    rda(40'h00_FFFE_0001);
    sat(32'h0000_00B1, 40'h7F_FFFF_FFFF, mdd_pkg::MAX_40, 6'b101011, 0);
    sat(32'h0000_00A1, 40'h00_7FFF_FFFF, mdd_pkg::MAX_32, 6'b001001, 0);
    apb(1, mdd_pkg::ADDR_TRAP_EN, 32'h0000_0004);
    sat(32'h0000_0021, 40'h7F_FFFF_FFFF, 40'h80_0000_0000, 6'b101011, 1);
    apb(1, mdd_pkg::ADDR_TRAP_EN, 32'h0000_0001);
    op(mdd_pkg::OP_LOAD_ACC, 0, 0, 40'h7F_FFFF_FFFF);
    #1;
    chk("guard trap", arith_trap, 1);
    report_and_stop;
  end
endmodule
`default_nettype wire
